// >>> shared/io_port_pkg.sv
`default_nettype none
package io_port_pkg;
	localparam logic [1:0] ADDR_BIDIR_DATA = 2'h0;
	localparam logic [1:0] ADDR_INPUT_DATA = 2'h1;
	localparam logic [1:0] ADDR_SERIAL_DATA = 2'h2;
	localparam logic [7:0] BIDIR_DATA_RESET = 8'h00;
	localparam logic [4:0] SERIAL_DATA_RESET = 5'h00;
	localparam logic [1:0] FUNC_OTHER = 2'h0;
	localparam logic [1:0] FUNC_OUTPUT = 2'h1;
	localparam logic [1:0] FUNC_IN_PULLUP = 2'h2;
	localparam logic [1:0] FUNC_IN_PLAIN = 2'h3;
	localparam logic [1:0] FUNC_AFTER_RESET = 2'h2;
	localparam int BIDIR_PINS = 7;
	localparam int INPUT_PINS = 4;
	localparam int SERIAL_PINS = 6;
	localparam int SERIAL_RW_BITS = 5;
	// Reserved bits that the hardware leaves undefined read as this
	localparam logic UNDEF_BIT = 1'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage
`default_nettype wire

// >>> core/pin_sync.sv
`default_nettype none
// Two flip-flop synchroniser for a bus of pin levels
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule // pin_sync

// >>> core/pin_slice.sv
`default_nettype none
// Per-pin function decode: output enable and read source
module pin_slice #(
	parameter int WIDTH = 1
) (
	input wire logic [2*WIDTH-1:0] func,
	input wire logic [WIDTH-1:0] stored,
	input wire logic [WIDTH-1:0] pin_level,
	output logic [WIDTH-1:0] drive_en,
	output logic [WIDTH-1:0] pullup_en,
	output logic [WIDTH-1:0] read_val
);
	// Decode of the two-bit function code
	function automatic logic [2:0] decode(input logic [1:0] code, input logic st, input logic pin);
		logic [2:0] r;
		r = 3'h0;
		case (code)
			io_port_pkg::FUNC_OTHER: r = {1'b0, 1'b0, st};
			io_port_pkg::FUNC_OUTPUT: r = {1'b1, 1'b0, st};
			io_port_pkg::FUNC_IN_PULLUP: r = {1'b0, 1'b1, pin};
			io_port_pkg::FUNC_IN_PLAIN: r = {1'b0, 1'b0, pin};
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	for (genvar i = 0; i < WIDTH; i++) begin : g_pin
		wire [2:0] d = decode(func[2*i+1:2*i], stored[i], pin_level[i]);
		assign drive_en[i] = d[2];
		assign pullup_en[i] = d[1];
		assign read_val[i] = d[0];
	end
endmodule // pin_slice

// >>> core/io_port_data.sv
// The plain strobed port and the register offsets were decided locally.
`default_nettype none
// Data registers of the bidirectional, input-only and serial-pin ports
module io_port_data (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic [13:0] bidir_func,
	input wire logic [7:0] input_func,
	input wire logic [11:0] serial_func,
	input wire logic [6:0] bidir_pin_in,
	output logic [6:0] bidir_pin_out,
	output logic [6:0] bidir_pin_oe,
	output logic [6:0] bidir_pullup,
	input wire logic [3:0] input_pin_in,
	input wire logic [5:0] serial_pin_in,
	output logic [4:0] serial_pin_out,
	output logic [4:0] serial_pin_oe,
	output logic [5:0] serial_pullup
);
	logic [6:0] bidir_data_reg;
	logic [6:0] bidir_data_next;
	logic [4:0] serial_data_reg;
	logic [4:0] serial_data_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [6:0] bidir_sync;
	logic [3:0] input_sync;
	logic [5:0] serial_sync;
	logic [6:0] bidir_rd;
	logic [4:0] serial_rd;
	logic [6:0] bidir_oe_w;
	logic [4:0] serial_oe_w;
	logic [4:0] serial_pu_low;

	// Pins come from the board, so every level is synchronised
	pin_sync #(.WIDTH(7)) u_sync_bidir (
		.clk(clk),
		.rst(rst),
		.async_in(bidir_pin_in),
		.sync_out(bidir_sync)
	);
	pin_sync #(.WIDTH(4)) u_sync_input (
		.clk(clk),
		.rst(rst),
		.async_in(input_pin_in),
		.sync_out(input_sync)
	);
	pin_sync #(.WIDTH(6)) u_sync_serial (
		.clk(clk),
		.rst(rst),
		.async_in(serial_pin_in),
		.sync_out(serial_sync)
	);

	// Function settings are inputs, not stored here
	pin_slice #(.WIDTH(7)) u_bidir_slice (
		.func(bidir_func),
		.stored(bidir_data_reg),
		.pin_level(bidir_sync),
		.drive_en(bidir_oe_w),
		.pullup_en(bidir_pullup),
		.read_val(bidir_rd)
	);
	pin_slice #(.WIDTH(5)) u_serial_slice (
		.func(serial_func[9:0]),
		.stored(serial_data_reg),
		.pin_level(serial_sync[4:0]),
		.drive_en(serial_oe_w),
		.pullup_en(serial_pu_low),
		.read_val(serial_rd)
	);

	// Input-only bits: low unless an input function is chosen
	wire [3:0] input_rd;
	for (genvar j = 0; j < 4; j++) begin : g_in
		assign input_rd[j] = input_func[2*j+1] & input_sync[j];
	end
	wire serial_bit5_rd = serial_func[11] & serial_sync[5];
	assign serial_pullup = {serial_func[11:10] == io_port_pkg::FUNC_IN_PULLUP, serial_pu_low};

	// Address decode
	wire sel_bidir = addr == io_port_pkg::ADDR_BIDIR_DATA;
	wire sel_input = addr == io_port_pkg::ADDR_INPUT_DATA;
	wire sel_serial = addr == io_port_pkg::ADDR_SERIAL_DATA;

	// Writes store the bit whatever the function; input port has no store
	assign bidir_data_next = (wr_en && sel_bidir) ? wdata[6:0] : bidir_data_reg;
	assign serial_data_next = (wr_en && sel_serial) ? wdata[4:0] : serial_data_reg;

	// Read mux; reserved undefined bits read as a fixed level
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_en) begin
			if (sel_bidir)
				rdata_next = {io_port_pkg::UNDEF_BIT, bidir_rd};
			else if (sel_input)
				rdata_next = {4'h0, input_rd};
			else if (sel_serial)
				rdata_next = {io_port_pkg::UNDEF_BIT, io_port_pkg::UNDEF_BIT,
					serial_bit5_rd, serial_rd};
			else
				rdata_next = io_port_pkg::UNMAPPED_READ;
		end
	end

	// Only rst (power-on) clears; other resets never reach here
	always_ff @(posedge clk) begin
		if (rst) begin
			bidir_data_reg <= io_port_pkg::BIDIR_DATA_RESET[6:0];
			serial_data_reg <= io_port_pkg::SERIAL_DATA_RESET;
			rdata_reg <= 8'h00;
		end else begin
			bidir_data_reg <= bidir_data_next;
			serial_data_reg <= serial_data_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign bidir_pin_out = bidir_data_reg;
	assign bidir_pin_oe = bidir_oe_w;
	assign serial_pin_out = serial_data_reg;
	assign serial_pin_oe = serial_oe_w;

	chk_bidir_reset: assert property (@(posedge clk) rst |=> bidir_data_reg == 7'h00)
		else $error("bidir reg not cleared");
	chk_serial_reset: assert property (@(posedge clk) rst |=> serial_data_reg == 5'h00)
		else $error("serial reg not cleared");
	chk_bidir_write: assert property (@(posedge clk) disable iff (rst)
		wr_en && sel_bidir |=> bidir_data_reg == $past(wdata[6:0]))
		else $error("bidir write lost");
	chk_input_read: assert property (@(posedge clk) disable iff (rst)
		rd_en && sel_input |=> rdata[7:4] == 4'h0)
		else $error("input upper bits not zero");
	chk_output_drive: assert property (@(posedge clk) disable iff (rst)
		bidir_func[1:0] == io_port_pkg::FUNC_OUTPUT |-> bidir_pin_oe[0] && bidir_pin_out[0] == bidir_data_reg[0])
		else $error("output not driven");
	chk_input_nodrive: assert property (@(posedge clk) disable iff (rst)
		bidir_func[1:0] != io_port_pkg::FUNC_OUTPUT |-> !bidir_pin_oe[0])
		else $error("pin driven outside output");
	chk_read_source: assert property (@(posedge clk) disable iff (rst)
		rd_en && sel_bidir && bidir_func[1] |=> rdata[0] == $past(bidir_sync[0]))
		else $error("input read not pin");
	chk_read_stored: assert property (@(posedge clk) disable iff (rst)
		rd_en && sel_bidir && !bidir_func[1] |=> rdata[0] == $past(bidir_data_reg[0]))
		else $error("output read not stored");
	chk_jbit_other: assert property (@(posedge clk) disable iff (rst)
		rd_en && sel_input && input_func[1:0] == 2'h0 |=> rdata[0] == 1'b0)
		else $error("input bit not low");
	chk_serial5_ro: assert property (@(posedge clk) disable iff (rst)
		rd_en && sel_serial && serial_func[11:10] == 2'h0 |=> rdata[5] == 1'b0)
		else $error("serial bit5 not low");

	// Steps of a register access as this block sees them on its port
	sequence seq_bidir_wr;
		wr_en && sel_bidir;
	endsequence
	sequence seq_serial_wr;
		wr_en && sel_serial;
	endsequence
	sequence seq_input_wr;
		wr_en && sel_input;
	endsequence
	sequence seq_bidir_rd;
		rd_en && sel_bidir;
	endsequence
	sequence seq_input_rd;
		rd_en && sel_input;
	endsequence
	sequence seq_serial_rd;
		rd_en && sel_serial;
	endsequence
	sequence seq_unmapped_rd;
		rd_en && !sel_bidir && !sel_input && !sel_serial;
	endsequence

	// Stored bits move only on their own write; sleep or standby never reach here
	chk_bidir_hold: assert property (@(posedge clk) disable iff (rst)
		!(wr_en && sel_bidir) |=> $stable(bidir_data_reg))
		else $error("bidir reg changed without write");
	chk_serial_hold: assert property (@(posedge clk) disable iff (rst)
		!(wr_en && sel_serial) |=> $stable(serial_data_reg))
		else $error("serial reg changed without write");
	chk_serial_write: assert property (@(posedge clk) disable iff (rst)
		seq_serial_wr |=> serial_data_reg == $past(wdata[4:0]))
		else $error("serial write lost");
	// A write to the input-only port leaves every store alone
	chk_input_nowrite: assert property (@(posedge clk) disable iff (rst)
		seq_input_wr |=> $stable(bidir_data_reg) && $stable(serial_data_reg))
		else $error("input port write stored");

	// Read data stand until the next read strobe, so a slow master still sees them
	chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
		!rd_en |=> $stable(rdata))
		else $error("read data moved without read");

	// Synchronisers and read data start from zero, so no stale pin reads after reset
	chk_rdata_reset: assert property (@(posedge clk)
		rst |=> rdata == 8'h00)
		else $error("read data not cleared");
	chk_sync_reset: assert property (@(posedge clk)
		rst |=> bidir_sync == 7'h00 && input_sync == 4'h0 && serial_sync == 6'h00)
		else $error("synchronisers not cleared");

	// Unmapped offset answers zero rather than bus noise
	chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		seq_unmapped_rd |=> rdata == io_port_pkg::UNMAPPED_READ)
		else $error("unmapped read not zero");

	// Reserved bits read a fixed level; software must not rely on it
	chk_bidir_reserved: assert property (@(posedge clk) disable iff (rst)
		seq_bidir_rd |=> rdata[7] == io_port_pkg::UNDEF_BIT)
		else $error("bidir bit7 not fixed");
	chk_serial_reserved: assert property (@(posedge clk) disable iff (rst)
		seq_serial_rd |=> rdata[7:6] == {2{io_port_pkg::UNDEF_BIT}})
		else $error("serial bits 7:6 not fixed");

	// Serial bit5 has no store: pin level under an input function, low otherwise
	chk_serial5_pin: assert property (@(posedge clk) disable iff (rst)
		seq_serial_rd ##0 serial_func[11] |=> rdata[5] == $past(serial_sync[5]))
		else $error("serial bit5 not pin");
	chk_serial5_pullup: assert property (@(posedge clk) disable iff (rst)
		serial_pullup[5] == (serial_func[11:10] == io_port_pkg::FUNC_IN_PULLUP))
		else $error("serial bit5 pullup wrong");

	// Every bidir pin: drive, pull-up, read source and write path
	for (genvar i = 0; i < 7; i++) begin : g_chk_bidir
		chk_pin_oe: assert property (@(posedge clk) disable iff (rst)
			bidir_pin_oe[i] == (bidir_func[2*i+:2] == io_port_pkg::FUNC_OUTPUT))
			else $error("bidir drive enable wrong");

		chk_pin_pullup: assert property (@(posedge clk) disable iff (rst)
			bidir_pullup[i] == (bidir_func[2*i+:2] == io_port_pkg::FUNC_IN_PULLUP))
			else $error("bidir pullup wrong");

		// Input functions read the pin as synchronised at the strobe
		chk_pin_read: assert property (@(posedge clk) disable iff (rst)
			seq_bidir_rd ##0 bidir_func[2*i+1] |=> rdata[i] == $past(bidir_sync[i]))
			else $error("bidir input read not pin");

		// Output and other functions read the stored bit
		chk_stored_read: assert property (@(posedge clk) disable iff (rst)
			seq_bidir_rd ##0 !bidir_func[2*i+1] |=> rdata[i] == $past(bidir_data_reg[i]))
			else $error("bidir output read not stored");

		// Only the output function may put a write on the pin
		chk_pin_drive: assert property (@(posedge clk) disable iff (rst)
			seq_bidir_wr ##0 bidir_func[2*i+:2] == io_port_pkg::FUNC_OUTPUT
			|=> bidir_pin_out[i] == $past(wdata[i]))
			else $error("bidir write not on pin");

		// Write then read at once: output and other functions give the bit back
		chk_write_readback: assert property (@(posedge clk) disable iff (rst)
			seq_bidir_wr ##1 (seq_bidir_rd ##0 !bidir_func[2*i+1])
			|=> rdata[i] == $past(wdata[i], 2))
			else $error("bidir write not read back");
	end

	// Serial bits 4:0 follow the same drive, pull-up and read rules
	for (genvar k = 0; k < 5; k++) begin : g_chk_serial
		chk_pin_oe: assert property (@(posedge clk) disable iff (rst)
			serial_pin_oe[k] == (serial_func[2*k+:2] == io_port_pkg::FUNC_OUTPUT))
			else $error("serial drive enable wrong");

		chk_pin_pullup: assert property (@(posedge clk) disable iff (rst)
			serial_pullup[k] == (serial_func[2*k+:2] == io_port_pkg::FUNC_IN_PULLUP))
			else $error("serial pullup wrong");

		chk_pin_read: assert property (@(posedge clk) disable iff (rst)
			seq_serial_rd ##0 serial_func[2*k+1] |=> rdata[k] == $past(serial_sync[k]))
			else $error("serial input read not pin");

		chk_stored_read: assert property (@(posedge clk) disable iff (rst)
			seq_serial_rd ##0 !serial_func[2*k+1] |=> rdata[k] == $past(serial_data_reg[k]))
			else $error("serial output read not stored");

		chk_pin_drive: assert property (@(posedge clk) disable iff (rst)
			seq_serial_wr ##0 serial_func[2*k+:2] == io_port_pkg::FUNC_OUTPUT
			|=> serial_pin_out[k] == $past(wdata[k]))
			else $error("serial write not on pin");

		chk_write_readback: assert property (@(posedge clk) disable iff (rst)
			seq_serial_wr ##1 (seq_serial_rd ##0 !serial_func[2*k+1])
			|=> rdata[k] == $past(wdata[k], 2))
			else $error("serial write not read back");
	end

	// Input-only bits: pin level under an input function, low otherwise
	for (genvar m = 0; m < 4; m++) begin : g_chk_input
		chk_pin_read: assert property (@(posedge clk) disable iff (rst)
			seq_input_rd ##0 input_func[2*m+1] |=> rdata[m] == $past(input_sync[m]))
			else $error("input read not pin");

		chk_low_read: assert property (@(posedge clk) disable iff (rst)
			seq_input_rd ##0 !input_func[2*m+1] |=> !rdata[m])
			else $error("input read not low");
	end
endmodule // io_port_data
`default_nettype wire

// >>> verif/board_pins.sv
`default_nettype none
// Board side of the pins; pull-ups are not modelled, the board always drives
module board_pins (
	input wire logic [6:0] bidir_out,
	input wire logic [6:0] bidir_oe,
	input wire logic [4:0] serial_out,
	input wire logic [4:0] serial_oe,
	input wire logic [16:0] board_level,
	output logic [6:0] bidir_in,
	output logic [3:0] input_in,
	output logic [5:0] serial_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Driven pins follow the port, the rest follow the board
	assign bidir_in = (bidir_oe & bidir_out) | (~bidir_oe & board_level[6:0]);
	assign input_in = board_level[10:7];
	assign serial_in = {board_level[16], (serial_oe & serial_out) | (~serial_oe & board_level[15:11])};
endmodule // board_pins
`default_nettype wire

// >>> verif/io_port_data_registers_h_j_sc_test.sv
`default_nettype none
module io_port_data_registers_h_j_sc_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, rst = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00, rdata, jf, s8;
	logic [13:0] bf;
	logic [11:0] sf;
	logic [16:0] ext;
	logic [6:0] bpi, bpo, boe, bpu, bm;
	logic [3:0] jpi;
	logic [5:0] spi, spu;
	logic [4:0] spo, soe, sm;
	logic [1:0] wa;
	int bad_count = 0, total_checks = 0;
	always #20 clk = ~clk;
	io_port_data u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .bidir_func(bf), .input_func(jf), .serial_func(sf),
		.bidir_pin_in(bpi), .bidir_pin_out(bpo), .bidir_pin_oe(boe), .bidir_pullup(bpu),
		.input_pin_in(jpi), .serial_pin_in(spi), .serial_pin_out(spo), .serial_pin_oe(soe),
		.serial_pullup(spu));
	board_pins u_board (.bidir_out(bpo), .bidir_oe(boe), .serial_out(spo), .serial_oe(soe),
		.board_level(ext), .bidir_in(bpi), .input_in(jpi), .serial_in(spi));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Expected read value from stored copies and live pins
	function automatic logic [7:0] exp_rd(input logic [1:0] a);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 7; i++) begin
			if (a == 2'h0) r[i] = bf[2*i+1] ? bpi[i] : bm[i];
			if (a == 2'h1 && i < 4) r[i] = (jf[2*i+:2] != 2'h0) & jpi[i];
			if (a == 2'h2 && i < 5) r[i] = sf[2*i+1] ? spi[i] : sm[i];
		end
		if (a == 2'h2) r[5] = (sf[11:10] != 2'h0) & spi[5];
		return r;
	endfunction
	function automatic logic [7:0] dec(input logic [13:0] f, input logic [1:0] code);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 7; i++) r[i] = (f[2*i+:2] == code);
		return r;
	endfunction
	// Code 01 is prohibited on input-only bits, so it is turned into 11
	function automatic logic [7:0] fix(input logic [7:0] f);
		for (int i = 0; i < 4; i++) f[2*i+1] = f[2*i+1] | f[2*i];
		return f;
	endfunction
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
		if (a == 2'h0) bm = d[6:0];
		if (a == 2'h2) sm = d[4:0];
	endtask
	task automatic rd(input logic [1:0] a);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		// Read data stand through the next cycle; look at its closing edge
		@(posedge clk);
		chk(rdata, exp_rd(a));
	endtask
	task automatic pins();
		chk({1'h0, bpo}, {1'h0, bm});
		chk({1'h0, boe}, dec(bf, io_port_pkg::FUNC_OUTPUT));
		chk({1'h0, bpu}, dec(bf, io_port_pkg::FUNC_IN_PULLUP));
		chk({3'h0, spo}, {3'h0, sm});
		chk({3'h0, soe}, dec({2'h0, sf}, io_port_pkg::FUNC_OUTPUT) & 8'h1F);
		chk({2'h0, spu}, dec({2'h0, sf}, io_port_pkg::FUNC_IN_PULLUP) & 8'h3F);
	endtask
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'hC39E95DB));
		bf = {7{io_port_pkg::FUNC_AFTER_RESET}};
		jf = {4{io_port_pkg::FUNC_AFTER_RESET}};
		sf = {6{io_port_pkg::FUNC_AFTER_RESET}};
		ext = 17'($urandom);
		bm = 7'h00;
		sm = 5'h00;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		rd(2'h0);
		rd(2'h2);
		pins();
		// Random functions, pin levels and writes, then every address read back
		for (int n = 0; n < 40; n++) begin
			bf <= 14'($urandom);
			jf <= fix(8'($urandom));
			s8 = fix({6'h00, 2'($urandom)});
			sf <= {s8[1:0], 10'($urandom)};
			ext <= 17'($urandom);
			repeat (3) @(posedge clk);
			wa = 2'($urandom);
			wr(wa, 8'($urandom));
			// Written register is read first, straight after the write
			for (int a = 0; a < 4; a++) rd(wa + 2'(a));
			pins();
		end
		// Second reset with every bidir pin and serial bits 4:0 outputs (serial bit5 input pull-up): stored bits must clear
		bf <= {7{io_port_pkg::FUNC_OUTPUT}};
		sf <= {2'h2, {5{io_port_pkg::FUNC_OUTPUT}}};
		wr(2'h0, 8'hFF);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		bm = 7'h00;
		sm = 5'h00;
		repeat (3) @(posedge clk);
		rd(2'h0);
		rd(2'h2);
		pins();
		close_out();
	end
endmodule // io_port_data_registers_h_j_sc_test
`default_nettype wire
